//--- include/aofc_pkg.sv
// Package for the converter output formatting and configuration block
package aofc_pkg;
  localparam int          ADDR_W          = 5;
  localparam int          REG_W           = 11;
  localparam int          SAMPLE_W        = 14;
  localparam int          LANE_W          = 7;
  localparam int          FIFO_DEPTH      = 4;
  // Register offsets
  localparam logic [4:0]  REG_TIMING      = 5'h04;
  localparam logic [4:0]  REG_ORDER       = 5'h09;
  localparam logic [4:0]  REG_FORMAT      = 5'h0A;
  localparam logic [4:0]  REG_USER_LO     = 5'h0B;
  localparam logic [4:0]  REG_GAIN_USR_HI = 5'h0C;
  localparam logic [4:0]  REG_DRIVE       = 5'h0E;
  // Field positions
  localparam int          CLK_DELAY_BIT   = 8;
  localparam int          CAP_EDGE_BIT    = 9;
  localparam int          DATA_SHIFT_BIT  = 10;
  localparam int          BYTE_ORDER_BIT  = 10;
  localparam int          FORMAT_BIT      = 10;
  localparam int          PAT_LSB         = 5;
  localparam int          USER_LO_LSB     = 4;
  localparam int          USER_HI_LSB     = 0;
  localparam int          GAIN_LSB        = 8;
  localparam int          BOOST_DATA_BIT  = 0;
  localparam int          BOOST_CLK_BIT   = 1;
  localparam int          CURR_LSB        = 2;
  localparam int          CTERM_LSB       = 4;
  localparam int          DTERM_LSB       = 7;
  // Output clock delay step and test words
  localparam int          CLK_DELAY_PS    = 400;
  localparam logic [13:0] WORD_ZERO       = 14'h0000;
  localparam logic [13:0] WORD_ONES       = 14'h3FFF;
  localparam logic [13:0] WORD_TOGGLE_A   = 14'h2AAA;
  localparam logic [13:0] WORD_TOGGLE_B   = 14'h1555;
  // Driver current in quarter milliamps
  localparam logic [5:0]  CURR_QMA_00     = 6'h0E;
  localparam logic [5:0]  CURR_QMA_01     = 6'h0A;
  localparam logic [5:0]  CURR_QMA_10     = 6'h12;
  localparam logic [5:0]  CURR_QMA_11     = 6'h07;
  localparam logic [2:0]  GAIN_UNUSED     = 3'h7;

  typedef enum logic [2:0] {
    PAT_NORMAL = 3'b000,
    PAT_ZEROS  = 3'b001,
    PAT_ONES   = 3'b010,
    PAT_TOGGLE = 3'b011,
    PAT_RAMP   = 3'b100,
    PAT_USER   = 3'b101
  } aofc_pat_t;

  typedef struct packed {
    logic       clk_delay;
    logic       cap_falling;
    logic       data_shift;
    logic       byte_order;
    logic       straight_bin;
    logic [2:0] pat;
    logic [6:0] user_lo;
    logic [4:0] user_hi;
    logic [2:0] gain;
    logic [1:0] curr;
    logic       boost_data;
    logic       boost_clk;
    logic [2:0] dterm;
    logic [2:0] cterm;
  } aofc_cfg_t;

  typedef struct packed {
    logic [5:0] data_qma;
    logic [5:0] clk_qma;
    logic [2:0] data_term;
    logic [2:0] clk_term;
  } aofc_drive_t;
endpackage : aofc_pkg

//--- hdl/aofc_core.sv
// Output formatting, test patterns and configuration registers of the converter output port
`timescale 1ns/1ns
// What this block does
// - Timing bit 8 set delays the output clock by 400 ps; clear keeps default.
// - Edge bit 9 tells the receiver: 0 capture on rising, 1 on falling.
// - Shift bit 10 set moves every sample bus transition half an output clock later; DDR lane updates stay on both clock edges.
// - DDR with ordering 0: even bits on rising edge, odd bits on falling.
// - DDR with ordering 1: lower bits on rising edge, upper bits on falling.
// - Pattern 000 normal, 001 zeros, 010 ones; 110 and 111 not programmed.
// - Pattern 011 alternates 0x2AAA and 0x1555 on successive samples.
// - Pattern 100 ramps from 0x0000 up one code per sample to 0x3FFF.
// - Pattern 101 outputs the constant user pattern word.
// - Format bit 0 gives two's complement, 1 gives straight binary.
// - User low field, bits 10..4 of register 0B, is pattern bits 6..0.
// - User high field, bits 4..0 of register 0C, is pattern bits 11..7.
// - Current field: 00 3.5 mA, 01 2.5, 10 4.5, 11 1.75 mA.
// - Data boost bit doubles the data driver current.
// - Clock boost bit doubles the clock driver current.
// - Data termination codes: none, 300, 185, 115, 150, 100, 80, 65 ohms.
// - Clock termination uses the same code mapping as data termination.
// - Bit or byte ordering only matters with the DDR interface active.

module aofc_fifo #(
  parameter int W     = 14,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic          ready_q;
  wire           push = in_valid && ready_q;
  wire           pop  = out_ready && (count_q != '0);

  assign count_d   = count_q + CW'(push) - CW'(pop);
  assign in_ready  = ready_q;
  assign out_valid = (count_q != '0);
  assign out_data  = mem[rd_ptr_q];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      ready_q  <= 1'b0;
    end else begin
      wr_ptr_q <= push ? PW'((wr_ptr_q + 1'b1) % DEPTH) : wr_ptr_q;
      rd_ptr_q <= pop ? PW'((rd_ptr_q + 1'b1) % DEPTH) : rd_ptr_q;
      count_q  <= count_d;
      ready_q  <= (count_d != CW'(DEPTH));
    end
  end

  // Storage carries no reset, only data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end
endmodule : aofc_fifo

module aofc_core
  import aofc_pkg::*;
#(
  parameter int W     = SAMPLE_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               arst_n,
  // Register port
  input  wire logic               wr_en,
  input  wire logic [ADDR_W-1:0]  wr_addr,
  input  wire logic [REG_W-1:0]   wr_data,
  input  wire logic               rd_en,
  input  wire logic [ADDR_W-1:0]  rd_addr,
  output logic [REG_W-1:0]        rd_data_q,
  // Conversion results, offset binary
  input  wire logic               conv_valid,
  input  wire logic [W-1:0]       conv_data,
  output logic                    conv_ready,
  // Sample clock pin and interface mode
  input  wire logic               sample_clk_pin,
  input  wire logic               ddr_mode,
  // Output port
  output logic [W-1:0]            sample_output_bus_q,
  output logic [LANE_W-1:0]       ddr_lane_q,
  output logic                    output_clock_pos_q,
  output logic                    clk_delay_q,
  output logic                    cap_falling_q,
  // Analog settings
  output logic [2:0]              gain_code_q,
  output aofc_drive_t             drive_q
);
  aofc_cfg_t cfg_q;
  logic      smp_s1_q;
  logic      smp_s2_q;
  logic      smp_s3_q;
  logic      ddr_s1_q;
  logic      ddr_s2_q;
  logic      tgl_q;
  logic [W-1:0] ramp_q;
  logic [W-1:0] word_d;
  logic [W-1:0] fifo_data;
  logic         fifo_valid;
  logic [W-1:0] last_conv_q;
  logic [LANE_W-1:0] lane_rise;
  logic [LANE_W-1:0] lane_fall;
  logic [REG_W-1:0]  rd_d;

  wire rise_tick = smp_s2_q && !smp_s3_q;
  wire fall_tick = !smp_s2_q && smp_s3_q;
  // Shift moves the word update to the falling half of the output clock
  wire upd_tick  = cfg_q.data_shift ? fall_tick : rise_tick;
  wire [W-1:0] conv_word = fifo_valid ? fifo_data : last_conv_q;
  // Source is offset binary, so two's complement only flips the sign bit
  wire [W-1:0] conv_fmt = cfg_q.straight_bin ? conv_word : {~conv_word[W-1], conv_word[W-2:0]};
  wire [11:0]  user_word = {cfg_q.user_hi, cfg_q.user_lo};

  // Test pattern select; unused codes fall back to conversion results
  always_comb begin
    case (cfg_q.pat)
      PAT_ZEROS:  word_d = W'(WORD_ZERO);
      PAT_ONES:   word_d = W'(WORD_ONES);
      PAT_TOGGLE: word_d = tgl_q ? W'(WORD_TOGGLE_B) : W'(WORD_TOGGLE_A);
      PAT_RAMP:   word_d = ramp_q;
      PAT_USER:   word_d = W'(user_word);
      default:    word_d = conv_fmt;
    endcase
  end

  // Stalled source when sample clock stops, so the queue truly fills
  aofc_fifo #(
    .W     (W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (conv_valid),
    .in_data   (conv_data),
    .in_ready  (conv_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (upd_tick)
  );

  // Lane selection per bit pair
  for (genvar i = 0; i < LANE_W; i++) begin : g_lane
    assign lane_rise[i] = cfg_q.byte_order ? sample_output_bus_q[i] : sample_output_bus_q[2*i];
    assign lane_fall[i] = cfg_q.byte_order ? sample_output_bus_q[i+LANE_W] : sample_output_bus_q[2*i+1];
  end

  // Register readback, reserved bits read as zero
  // Fields widened before shifting so no bit is lost to a narrow operand
  wire [REG_W-1:0] rd_timing = (REG_W'(cfg_q.clk_delay) << CLK_DELAY_BIT) |
                               (REG_W'(cfg_q.cap_falling) << CAP_EDGE_BIT) |
                               (REG_W'(cfg_q.data_shift) << DATA_SHIFT_BIT);
  wire [REG_W-1:0] rd_order  = REG_W'(cfg_q.byte_order) << BYTE_ORDER_BIT;
  wire [REG_W-1:0] rd_format = (REG_W'(cfg_q.straight_bin) << FORMAT_BIT) | (REG_W'(cfg_q.pat) << PAT_LSB);
  wire [REG_W-1:0] rd_user   = REG_W'(cfg_q.user_lo) << USER_LO_LSB;
  wire [REG_W-1:0] rd_gain   = (REG_W'(cfg_q.gain) << GAIN_LSB) | (REG_W'(cfg_q.user_hi) << USER_HI_LSB);
  wire [REG_W-1:0] rd_drive  = (REG_W'(cfg_q.dterm) << DTERM_LSB) | (REG_W'(cfg_q.cterm) << CTERM_LSB) |
                               (REG_W'(cfg_q.curr) << CURR_LSB) | (REG_W'(cfg_q.boost_clk) << BOOST_CLK_BIT) |
                               (REG_W'(cfg_q.boost_data) << BOOST_DATA_BIT);
  assign rd_d = (rd_addr == REG_TIMING) ? rd_timing :
                (rd_addr == REG_ORDER) ? rd_order :
                (rd_addr == REG_FORMAT) ? rd_format :
                (rd_addr == REG_USER_LO) ? rd_user :
                (rd_addr == REG_GAIN_USR_HI) ? rd_gain :
                (rd_addr == REG_DRIVE) ? rd_drive :
                REG_W'(0);

  // Configuration writes; fixed-zero positions are simply not stored
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= '0;
    end else if (wr_en) begin
      if (wr_addr == REG_TIMING) begin
        cfg_q.clk_delay   <= wr_data[CLK_DELAY_BIT];
        cfg_q.cap_falling <= wr_data[CAP_EDGE_BIT];
        cfg_q.data_shift  <= wr_data[DATA_SHIFT_BIT];
      end else if (wr_addr == REG_ORDER) begin
        cfg_q.byte_order <= wr_data[BYTE_ORDER_BIT];
      end else if (wr_addr == REG_FORMAT) begin
        cfg_q.straight_bin <= wr_data[FORMAT_BIT];
        cfg_q.pat          <= wr_data[PAT_LSB +: 3];
      end else if (wr_addr == REG_USER_LO) begin
        cfg_q.user_lo <= wr_data[USER_LO_LSB +: 7];
      end else if (wr_addr == REG_GAIN_USR_HI) begin
        cfg_q.gain    <= wr_data[GAIN_LSB +: 3];
        cfg_q.user_hi <= wr_data[USER_HI_LSB +: 5];
      end else if (wr_addr == REG_DRIVE) begin
        cfg_q.dterm      <= wr_data[DTERM_LSB +: 3];
        cfg_q.cterm      <= wr_data[CTERM_LSB +: 3];
        cfg_q.curr       <= wr_data[CURR_LSB +: 2];
        cfg_q.boost_clk  <= wr_data[BOOST_CLK_BIT];
        cfg_q.boost_data <= wr_data[BOOST_DATA_BIT];
      end
    end
  end

  // Pin synchronisers and edge history
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      smp_s1_q <= 1'b0;
      smp_s2_q <= 1'b0;
      smp_s3_q <= 1'b0;
      ddr_s1_q <= 1'b0;
      ddr_s2_q <= 1'b0;
    end else begin
      smp_s1_q <= sample_clk_pin;
      smp_s2_q <= smp_s1_q;
      smp_s3_q <= smp_s2_q;
      ddr_s1_q <= ddr_mode;
      ddr_s2_q <= ddr_s1_q;
    end
  end

  // Sample word path; an empty queue repeats the last result
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_output_bus_q <= '0;
      last_conv_q         <= '0;
      tgl_q               <= 1'b0;
      ramp_q              <= '0;
    end else if (upd_tick) begin
      sample_output_bus_q <= word_d;
      last_conv_q         <= conv_word;
      tgl_q               <= (cfg_q.pat == PAT_TOGGLE) ? !tgl_q : 1'b0;
      ramp_q              <= (cfg_q.pat == PAT_RAMP) ? ramp_q + 1'b1 : '0;
    end
  end

  // Output clock follows the sample clock; ordering only acts in DDR mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      output_clock_pos_q <= 1'b0;
      ddr_lane_q         <= '0;
    end else begin
      output_clock_pos_q <= smp_s2_q;
      if (!ddr_s2_q) begin
        ddr_lane_q <= '0;
      end else if (rise_tick) begin
        ddr_lane_q <= lane_rise;
      end else if (fall_tick) begin
        ddr_lane_q <= lane_fall;
      end
    end
  end

  // Analog settings and status; the 400 ps step is done by the pad delay cell
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_delay_q   <= 1'b0;
      cap_falling_q <= 1'b0;
      gain_code_q   <= '0;
      drive_q       <= '0;
      rd_data_q     <= '0;
    end else begin
      clk_delay_q        <= cfg_q.clk_delay;
      cap_falling_q      <= cfg_q.cap_falling;
      gain_code_q        <= (cfg_q.gain == GAIN_UNUSED) ? 3'h0 : cfg_q.gain;
      drive_q.data_qma   <= base_qma(cfg_q.curr) << cfg_q.boost_data;
      drive_q.clk_qma    <= base_qma(cfg_q.curr) << cfg_q.boost_clk;
      drive_q.data_term  <= cfg_q.dterm;
      drive_q.clk_term   <= cfg_q.cterm;
      rd_data_q          <= rd_en ? rd_d : rd_data_q;
    end
  end

  function automatic logic [5:0] base_qma(input logic [1:0] code);
    case (code)
      2'b00:   base_qma = CURR_QMA_00;
      2'b01:   base_qma = CURR_QMA_01;
      2'b10:   base_qma = CURR_QMA_10;
      default: base_qma = CURR_QMA_11;
    endcase
  endfunction : base_qma

  // Checks
  sequence s_upd_pat(logic [2:0] p);
    upd_tick && (cfg_q.pat == p);
  endsequence

  a_pattern_zeros: assert property (@(posedge clk) disable iff (!arst_n)
    s_upd_pat(PAT_ZEROS) |=> sample_output_bus_q == W'(WORD_ZERO))
    else $error("zero pattern not driven");

  a_pattern_ones: assert property (@(posedge clk) disable iff (!arst_n)
    s_upd_pat(PAT_ONES) |=> sample_output_bus_q == W'(WORD_ONES))
    else $error("ones pattern not driven");

  a_toggle_alternates: assert property (@(posedge clk) disable iff (!arst_n)
    s_upd_pat(PAT_TOGGLE) ##1 (upd_tick && cfg_q.pat == PAT_TOGGLE)
      |=> sample_output_bus_q != $past(sample_output_bus_q, 1))
    else $error("toggle pattern did not alternate");

  a_ramp_steps: assert property (@(posedge clk) disable iff (!arst_n)
    s_upd_pat(PAT_RAMP) |=> sample_output_bus_q == $past(ramp_q) && ramp_q == $past(ramp_q) + 1'b1)
    else $error("ramp did not step by one");

  a_user_word: assert property (@(posedge clk) disable iff (!arst_n)
    s_upd_pat(PAT_USER) |=> sample_output_bus_q == W'({$past(cfg_q.user_hi), $past(cfg_q.user_lo)}))
    else $error("user pattern word wrong");

  a_twos_sign: assert property (@(posedge clk) disable iff (!arst_n)
    s_upd_pat(PAT_NORMAL) && !cfg_q.straight_bin |=> sample_output_bus_q[W-1] == !$past(conv_word[W-1]))
    else $error("two's complement sign not flipped");

  a_shift_holds: assert property (@(posedge clk) disable iff (!arst_n)
    rise_tick && cfg_q.data_shift |=> $stable(sample_output_bus_q))
    else $error("data moved on rising edge while shifted");

  a_bitwise_lane: assert property (@(posedge clk) disable iff (!arst_n)
    rise_tick && ddr_s2_q && !cfg_q.byte_order |=> ddr_lane_q[1] == $past(sample_output_bus_q[2]))
    else $error("even bit not on rising edge");

  a_boost_double: assert property (@(posedge clk) disable iff (!arst_n)
    cfg_q.boost_data && cfg_q.curr == 2'b00 ##1 $stable(cfg_q) |-> drive_q.data_qma == 6'h1C)
    else $error("data current not doubled");

  a_clk_boost: assert property (@(posedge clk) disable iff (!arst_n)
    cfg_q.boost_clk && cfg_q.curr == 2'b11 ##1 $stable(cfg_q) |-> drive_q.clk_qma == 6'h0E)
    else $error("clock current not doubled");

  a_byte_lane: assert property (@(posedge clk) disable iff (!arst_n)
    rise_tick && ddr_s2_q && cfg_q.byte_order |=> ddr_lane_q == $past(sample_output_bus_q[LANE_W-1:0]))
    else $error("lower bits not on rising edge");

  a_lane_idle: assert property (@(posedge clk) disable iff (!arst_n)
    !ddr_s2_q |=> ddr_lane_q == '0)
    else $error("lane active outside DDR mode");

  a_gain_unused: assert property (@(posedge clk) disable iff (!arst_n)
    cfg_q.gain == GAIN_UNUSED |=> gain_code_q == 3'h0)
    else $error("unused gain code passed on");

  a_delay_follow: assert property (@(posedge clk) disable iff (!arst_n)
    1'b1 |=> clk_delay_q == $past(cfg_q.clk_delay))
    else $error("clock delay enable not exported");

  a_edge_follow: assert property (@(posedge clk) disable iff (!arst_n)
    1'b1 |=> cap_falling_q == $past(cfg_q.cap_falling))
    else $error("capture edge select not exported");
endmodule : aofc_core

//--- test/aofc_rx_model.sv
// Receiver model that captures the converter output port
`timescale 1ns/1ns
module aofc_rx_model
  import aofc_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // Output port under capture
  input  wire logic [SAMPLE_W-1:0] bus,
  input  wire logic [LANE_W-1:0]   lane,
  input  wire logic                ocp,
  input  wire logic                cap_falling,
  // Captured values
  output logic [SAMPLE_W-1:0]      word_q,
  output logic [LANE_W-1:0]        rise_lane_q,
  output logic [LANE_W-1:0]        fall_lane_q,
  output logic                     chg_lvl_q,
  output logic [15:0]              cap_cnt_q
);
  logic                ocp_q;
  logic [SAMPLE_W-1:0] bus_q;

  // Sampled on the fast clock, so edges of the output clock show one cycle late
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ocp_q       <= 1'b0;
      bus_q       <= '0;
      word_q      <= '0;
      rise_lane_q <= '0;
      fall_lane_q <= '0;
      chg_lvl_q   <= 1'b0;
      cap_cnt_q   <= '0;
    end else begin
      if (bus != bus_q) chg_lvl_q <= ocp;
      if (ocp != ocp_q && ocp != cap_falling) begin
        word_q    <= bus;
        cap_cnt_q <= cap_cnt_q + 16'h0001;
      end
      if (ocp && !ocp_q) rise_lane_q <= lane;
      if (!ocp && ocp_q) fall_lane_q <= lane;
      ocp_q <= ocp;
      bus_q <= bus;
    end
  end
endmodule : aofc_rx_model

//--- test/adc_output_format_config_tb.sv
// Testbench for the converter output formatting and configuration block
`timescale 1ns/1ns
module adc_output_format_config_tb
  import aofc_pkg::*;
;
  logic clk = 1'b0, arst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, conv_valid = 1'b0;
  logic pin = 1'b0, pin_run = 1'b1, ddr_mode = 1'b0;
  logic [4:0] wr_addr = '0, rd_addr = '0;
  logic [10:0] wr_data = '0, rd_data_q;
  logic [13:0] conv_data = '0, bus, word, pv;
  logic [6:0] lane, rise_lane, fall_lane;
  logic conv_ready, ocp, dly, capf, chg_lvl, r;
  logic [2:0] gain;
  logic [15:0] cap_cnt;
  logic [5:0] base;
  aofc_drive_t drv;
  int err_total = 0, n_checks = 0, cyc = 0, i, c, b, n;
  logic [4:0] rst_addrs [7] = '{REG_TIMING, REG_ORDER, REG_FORMAT, REG_USER_LO, REG_GAIN_USR_HI, REG_DRIVE, 5'h1F};
  logic [2:0] pats [3] = '{3'h1, 3'h2, 3'h5};
  logic [13:0] pat_words [3] = '{WORD_ZERO, WORD_ONES, 14'h0555};
  logic [10:0] orders [2] = '{11'h000, 11'h400};
  logic [13:0] lane_exp [2] = '{{7'h3F, 7'h00}, {7'h55, 7'h0A}};

  always #5 clk = ~clk;
  // Pin phase offset keeps its edges away from the fast clock
  initial begin
    #7;
    forever #40 pin = pin_run ? ~pin : 1'b0;
  end

  aofc_core dut_u (.clk(clk), .arst_n(arst_n), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_q(rd_data_q), .conv_valid(conv_valid),
    .conv_data(conv_data), .conv_ready(conv_ready), .sample_clk_pin(pin), .ddr_mode(ddr_mode),
    .sample_output_bus_q(bus), .ddr_lane_q(lane), .output_clock_pos_q(ocp), .clk_delay_q(dly),
    .cap_falling_q(capf), .gain_code_q(gain), .drive_q(drv));
  aofc_rx_model rx_u (.clk(clk), .arst_n(arst_n), .bus(bus), .lane(lane), .ocp(ocp), .cap_falling(capf),
    .word_q(word), .rise_lane_q(rise_lane), .fall_lane_q(fall_lane), .chg_lvl_q(chg_lvl),
    .cap_cnt_q(cap_cnt));

  task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [10:0] d);
    @(posedge clk);
    #1 wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(posedge clk);
    #1 wr_en = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [10:0] e, input string nm);
    @(posedge clk);
    #1 rd_en = 1'b1;
    rd_addr = a;
    @(posedge clk);
    #1 rd_en = 1'b0;
    @(posedge clk);
    #1 chk(nm, e, rd_data_q);
  endtask : rd

  // Bounded wait for captures by the receiver model
  task automatic wait_cap(input int k);
    logic [15:0] c0;
    int t;
    repeat (k) begin
      c0 = cap_cnt;
      for (t = 0; t < 200 && cap_cnt == c0; t++) @(posedge clk);
      if (cap_cnt == c0) chk("capture", 18'h1, 18'h0);
    end
    #1;
  endtask : wait_cap

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // Run takes about 500 cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      chk("timeout", 18'h0, 18'h1);
      end_of_test();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    #1 arst_n = 1'b1;
    foreach (rst_addrs[k])
      rd(rst_addrs[k], 11'h000, "reset");
    chk("drive reset", {CURR_QMA_00, CURR_QMA_00, 6'h00}, drv);
    chk("delay reset", 18'h0, {dly, capf});
    $display("test reset done");
    wr(REG_TIMING, 11'h300);
    chk("delay", 18'h3, {dly, capf});
    rd(REG_TIMING, 11'h300, "timing");
    wr(REG_TIMING, 11'h7FF);
    rd(REG_TIMING, 11'h700, "fixed zero");
    wr(5'h05, 11'h7FF);
    rd(5'h05, 11'h000, "unmapped");
    wr(REG_TIMING, 11'h000);
    $display("test timing done");
    for (i = 0; i < 8; i++) begin
      wr(REG_GAIN_USR_HI, {i[2:0], 3'h0, 5'h0A});
      chk("gain", (i == 7) ? 18'h0 : 18'(i), gain);
    end
    for (c = 0; c < 4; c++) begin
      for (b = 0; b < 4; b++) begin
        base = c == 0 ? CURR_QMA_00 : c == 1 ? CURR_QMA_01 : c == 2 ? CURR_QMA_10 : CURR_QMA_11;
        wr(REG_DRIVE, {1'b0, c[1:0], b[0], ~c[1:0], ~b[0], c[1:0], b[1:0]});
        chk("drive", {base << b[0], base << b[1], c[1:0], b[0], ~c[1:0], ~b[0]}, drv);
      end
    end
    $display("test analog done");
    wr(REG_USER_LO, 11'h550);
    foreach (pats[k]) begin
      wr(REG_FORMAT, {3'h0, pats[k], 5'h00});
      wait_cap(2);
      chk("pattern", pat_words[k], word);
    end
    wr(REG_FORMAT, 11'h060);
    wait_cap(2);
    for (i = 0; i < 4; i++) begin
      pv = word;
      wait_cap(1);
      chk("toggle", (pv == WORD_TOGGLE_A) ? WORD_TOGGLE_B : WORD_TOGGLE_A, word);
    end
    wr(REG_FORMAT, 11'h080);
    for (n = 0; n < 2; n++) begin
      wait_cap(2);
      chk("change level", 18'(n == 0), chg_lvl);
      for (i = 0; i < 3; i++) begin
        pv = word;
        wait_cap(1);
        chk("ramp", pv + 14'h0001, word);
      end
      wr(REG_TIMING, 11'h400);
    end
    wr(REG_TIMING, 11'h000);
    $display("test patterns done");
    wr(REG_FORMAT, 11'h0A0);
    ddr_mode = 1'b1;
    foreach (orders[k]) begin
      wr(REG_ORDER, orders[k]);
      wait_cap(3);
      chk("lanes", {4'h0, lane_exp[k]}, {4'h0, rise_lane, fall_lane});
    end
    ddr_mode = 1'b0;
    wait_cap(3);
    chk("lanes off", 18'h0, {rise_lane, fall_lane});
    $display("test ddr done");
    wr(REG_FORMAT, 11'h400);
    pin_run = 1'b0;
    repeat (20) @(posedge clk);
    #1 n = 0;
    for (i = 0; i < 6; i++) begin
      r = conv_ready;
      conv_valid = 1'b1;
      conv_data = 14'h1000 + 14'(n);
      @(posedge clk);
      #1 if (r === 1'b1) n++;
    end
    conv_valid = 1'b0;
    chk("fifo depth", 18'(FIFO_DEPTH), 18'(n));
    pin_run = 1'b1;
    for (i = 0; i < 4; i++) begin
      wait_cap(1);
      chk("fifo word", 14'h1000 + 14'(i), word);
    end
    wr(REG_FORMAT, 11'h000);
    conv_valid = 1'b1;
    conv_data = 14'h1234;
    @(posedge clk);
    #1 conv_valid = 1'b0;
    wait_cap(2);
    chk("twos complement", 14'h3234, word);
    wr(REG_FORMAT, 11'h0C0);
    wait_cap(2);
    chk("unused pattern", 14'h3234, word);
    $display("test stream done");
    end_of_test();
  end
endmodule : adc_output_format_config_tb
